// ---- common/enc_regs_consts.svh ----
`ifndef ENC_REGS_CONSTS_SVH
`define ENC_REGS_CONSTS_SVH

`define BANK_COUNT        10
`define BANK_BYTES        64
`define ADDR_WINDOW_LAST  7'h3f
`define ADDR_BANK_SEL     7'h40
`define ADDR_EXT_BANK     7'h41
`define ADDR_PROFILE      7'h42
`define ADDR_SERIAL       7'h44
`define ADDR_FAULT        7'h48
`define ADDR_WARNING      7'h49
`define ADDR_CLEAR        7'h4a
`define ADDR_PART         7'h78
`define ADDR_MAKER        7'h7e
`define FAULT_SUPPLY_BIT  4
`define FAULT_REV_BIT     3
`define FAULT_ST_BIT      2
`define FAULT_STORE_BIT   1
`define FAULT_CURR_BIT    0
`define FAULT_MASK        8'h1f
`define WARN_LIGHT_BIT    1
`define WARN_EMIT_BIT     0
`define WARN_MASK         8'h03
`define CLR_WARN_BIT      3
`define CLR_ERR_BIT       2
`define CLR_ST_BIT        1
`define CLR_MT_BIT        0
`define BANK_SEL_RESET    8'h00
`define READ_WAIT_BITS    4
`define FRAME_ADDR_BITS   7
`define FRAME_DATA_BITS   8

`endif

// ---- common/enc_regs_pkg.sv ----
package enc_regs_pkg;

  typedef enum logic [4:0] {
    LNK_IDLE = 5'b00001,
    LNK_HEAD = 5'b00010,
    LNK_WDAT = 5'b00100,
    LNK_WAIT = 5'b01000,
    LNK_RDAT = 5'b10000
  } link_state_e;

  typedef logic [6:0] reg_addr_t;
  typedef logic [7:0] reg_byte_t;

endpackage : enc_regs_pkg

// ---- hdl/encoder_serial_register_map.sv ----
`timescale 1ns/10ps
`include "enc_regs_consts.svh"

module encoder_serial_register_map #(
  parameter bit          BANK_SWITCH = 1'b1,
  parameter logic [15:0] PROFILE_IDENTIFIER  = 16'h0a5c, // Arbitrary value
  parameter logic [31:0] SERIAL_NUM  = 32'h1234_5678, // Arbitrary value
  parameter logic [47:0] PART_ID     = 48'h0102_0304_0506, // Arbitrary value
  parameter logic [15:0] MAKER_ID    = 16'h00ee // Arbitrary value
) (
  input  wire logic       clk_i,                  // Core clock
  input  wire logic       arst_n_i,               // Async reset, active low
  input  wire logic       master_serial_clock_i,  // Link clock from master
  input  wire logic       master_cmd_i,           // Command bit, link domain
  output logic            slave_serial_out_o,     // Read data bit
  input  wire logic [4:0] fault_event_i,          // Fault set pulses
  input  wire logic [1:0] warn_event_i,           // Warning set pulses
  output logic            clear_single_turn_o,    // One-cycle clear pulse
  output logic            clear_revolutions_o,    // One-cycle clear pulse
  output logic            frame_error_low_o,      // Low while faults set
  output logic            frame_warning_low_o     // Low while warnings set
);

  // Link domain
  enc_regs_pkg::link_state_e state_ff;
  enc_regs_pkg::link_state_e nxt_state;
  logic [3:0]                cnt_ff;
  logic [3:0]                nxt_cnt;
  logic                      rw_ff;
  logic [6:0]                addr_ff;
  logic [7:0]                wdat_ff;
  logic [7:0]                shout_ff;
  logic                      req_tgl_ff;
  logic                      ack_s1_ff;
  logic                      ack_s2_ff;
  logic                      ack_seen_ff;
  logic                      sout_ff;
  logic                      ack_tgl_ff;
  logic [7:0]                rdat_ff;

  wire head_done = (state_ff == enc_regs_pkg::LNK_HEAD) &&
                   (cnt_ff == 4'(`FRAME_ADDR_BITS));
  wire wdat_done = (state_ff == enc_regs_pkg::LNK_WDAT) &&
                   (cnt_ff == 4'(`FRAME_DATA_BITS - 1));
  wire wait_done = (state_ff == enc_regs_pkg::LNK_WAIT) &&
                   (cnt_ff == 4'(`READ_WAIT_BITS - 1));
  wire rdat_done = (state_ff == enc_regs_pkg::LNK_RDAT) &&
                   (cnt_ff == 4'(`FRAME_DATA_BITS - 1));
  wire ack_new   = ack_s2_ff != ack_seen_ff;
  wire issue_req = (head_done && !master_cmd_i) || wdat_done;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff + 4'h1;
    case (state_ff)
      enc_regs_pkg::LNK_IDLE:
      begin
        nxt_cnt = 4'h0;
        if (master_cmd_i)
        begin
          nxt_state = enc_regs_pkg::LNK_HEAD;
        end
      end
      enc_regs_pkg::LNK_HEAD:
      begin
        if (head_done)
        begin
          nxt_cnt   = 4'h0;
          nxt_state = master_cmd_i ? enc_regs_pkg::LNK_WDAT : enc_regs_pkg::LNK_WAIT;
        end
      end
      enc_regs_pkg::LNK_WDAT:
      begin
        if (wdat_done)
        begin
          nxt_state = enc_regs_pkg::LNK_IDLE;
        end
      end
      enc_regs_pkg::LNK_WAIT:
      begin
        if (wait_done)
        begin
          nxt_cnt   = 4'h0;
          nxt_state = enc_regs_pkg::LNK_RDAT;
        end
      end
      enc_regs_pkg::LNK_RDAT:
      begin
        if (rdat_done)
        begin
          nxt_state = enc_regs_pkg::LNK_IDLE;
        end
      end
      default:
      begin
        nxt_state = enc_regs_pkg::LNK_IDLE;
        nxt_cnt   = 4'h0;
      end
    endcase
  end

  always_ff @(posedge master_serial_clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_ff <= enc_regs_pkg::LNK_IDLE;
      cnt_ff   <= 4'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Header order: address MSB first, then the direction bit (1 = write)
  always_ff @(posedge master_serial_clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      addr_ff <= 7'h00;
    end
    else if (state_ff == enc_regs_pkg::LNK_HEAD && !head_done)
    begin
      addr_ff <= {addr_ff[5:0], master_cmd_i};
    end
  end

  always_ff @(posedge master_serial_clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rw_ff <= 1'b0;
    end
    else if (head_done)
    begin
      rw_ff <= master_cmd_i;
    end
  end

  always_ff @(posedge master_serial_clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wdat_ff <= 8'h00;
    end
    else if (state_ff == enc_regs_pkg::LNK_WDAT)
    begin
      wdat_ff <= {wdat_ff[6:0], master_cmd_i};
    end
  end

  // Request word stays frozen until the next frame, so one toggle suffices
  always_ff @(posedge master_serial_clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      req_tgl_ff <= 1'b0;
    end
    else if (issue_req)
    begin
      req_tgl_ff <= ~req_tgl_ff;
    end
  end

  always_ff @(posedge master_serial_clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ack_s1_ff   <= 1'b0;
      ack_s2_ff   <= 1'b0;
      ack_seen_ff <= 1'b0;
    end
    else
    begin
      ack_s1_ff <= ack_tgl_ff;
      ack_s2_ff <= ack_s1_ff;
      if (ack_new)
      begin
        ack_seen_ff <= ack_s2_ff;
      end
    end
  end

  // Read answer: zero if the core has not answered by the end of the wait
  always_ff @(posedge master_serial_clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      shout_ff <= 8'h00;
      sout_ff  <= 1'b1;
    end
    else
    begin
      if (state_ff == enc_regs_pkg::LNK_HEAD)
      begin
        shout_ff <= 8'h00;
      end
      else if (state_ff == enc_regs_pkg::LNK_WAIT && ack_new)
      begin
        shout_ff <= rdat_ff;
      end
      else if (state_ff == enc_regs_pkg::LNK_RDAT)
      begin
        shout_ff <= {shout_ff[6:0], 1'b0};
      end
      sout_ff <= (nxt_state == enc_regs_pkg::LNK_RDAT) ?
                 ((state_ff == enc_regs_pkg::LNK_WAIT) ?
                  (ack_new ? rdat_ff[7] : shout_ff[7]) : shout_ff[6]) : 1'b1;
    end
  end

  assign slave_serial_out_o = sout_ff;

  // Core domain
  logic [7:0] mem [0:`BANK_COUNT*`BANK_BYTES-1];
  logic       req_s1_ff;
  logic       req_s2_ff;
  logic       req_s3_ff;
  logic [7:0] bank_ff;
  logic [7:0] fault_ff;
  logic [7:0] nxt_fault;
  logic [7:0] warn_ff;
  logic [7:0] nxt_warn;
  logic       clr_st_ff;
  logic       clr_mt_ff;
  logic       err_low_ff;
  logic       war_low_ff;

  wire       req_strobe = req_s2_ff ^ req_s3_ff;
  wire       do_write   = req_strobe && rw_ff;  // Identity bytes have no write path
  wire [6:0] a          = addr_ff;
  wire       in_window  = a <= `ADDR_WINDOW_LAST;
  wire       bank_ok    = BANK_SWITCH && (bank_ff < 8'(`BANK_COUNT));
  wire [9:0] mem_idx    = 10'(bank_ff[3:0] * `BANK_BYTES) + {4'h0, a[5:0]};
  wire [7:0] fault_rd   = fault_ff & `FAULT_MASK;
  wire [7:0] warn_rd    = warn_ff & `WARN_MASK;

  // Identity bytes: byte 0 of each field is its most significant byte
  wire [7:0] prof_byte  = PROFILE_IDENTIFIER[8*(1-a[0]) +: 8];
  wire [7:0] ser_byte   = SERIAL_NUM[8*(3-a[1:0]) +: 8];
  wire [2:0] part_off   = 3'(a - `ADDR_PART);
  wire [7:0] part_byte  = PART_ID[8*(5-part_off) +: 8];
  wire [7:0] maker_byte = MAKER_ID[8*(1-a[0]) +: 8];

  wire is_prof  = a[6:1] == `ADDR_PROFILE >> 1;
  wire is_ser   = a[6:2] == `ADDR_SERIAL >> 2;
  wire is_part  = (a >= `ADDR_PART) && (a < `ADDR_MAKER);
  wire is_maker = a[6:1] == `ADDR_MAKER >> 1;

  // Unlisted addresses, the absent extended bank and the clear byte read zero
  wire [7:0] rd_mux =
    (in_window && bank_ok)        ? mem[mem_idx] :
    (a == `ADDR_BANK_SEL && BANK_SWITCH) ? bank_ff :
    is_prof                       ? prof_byte :
    is_ser                        ? ser_byte :
    (a == `ADDR_FAULT)            ? fault_rd :
    (a == `ADDR_WARNING)          ? warn_rd :
    is_part                       ? part_byte :
    is_maker                      ? maker_byte :
    8'h00;

  wire wr_clear = do_write && (a == `ADDR_CLEAR);
  wire clr_err  = wr_clear && wdat_ff[`CLR_ERR_BIT];
  wire clr_warn = wr_clear && wdat_ff[`CLR_WARN_BIT];

  // Event pulses win over a same-cycle clear
  always_comb
  begin
    nxt_fault = clr_err ? 8'h00 : fault_ff;
    nxt_fault[`FAULT_SUPPLY_BIT] = nxt_fault[`FAULT_SUPPLY_BIT] | fault_event_i[4];
    nxt_fault[`FAULT_REV_BIT]    = nxt_fault[`FAULT_REV_BIT] | fault_event_i[3];
    nxt_fault[`FAULT_ST_BIT]     = nxt_fault[`FAULT_ST_BIT] | fault_event_i[2];
    nxt_fault[`FAULT_STORE_BIT]  = nxt_fault[`FAULT_STORE_BIT] | fault_event_i[1];
    nxt_fault[`FAULT_CURR_BIT]   = nxt_fault[`FAULT_CURR_BIT] | fault_event_i[0];
    nxt_warn = clr_warn ? 8'h00 : warn_ff;
    nxt_warn[`WARN_LIGHT_BIT] = nxt_warn[`WARN_LIGHT_BIT] | warn_event_i[1];
    nxt_warn[`WARN_EMIT_BIT]  = nxt_warn[`WARN_EMIT_BIT] | warn_event_i[0];
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
      req_s3_ff <= 1'b0;
    end
    else
    begin
      req_s1_ff <= req_tgl_ff;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
    end
  end

  // Answer toggles after the read byte is stable
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdat_ff    <= 8'h00;
      ack_tgl_ff <= 1'b0;
    end
    else if (req_strobe)
    begin
      rdat_ff    <= rw_ff ? 8'h00 : rd_mux;
      ack_tgl_ff <= ~ack_tgl_ff;
    end
  end

  // Out-of-range bank values are kept but hide the window
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bank_ff <= `BANK_SEL_RESET;
    end
    else if (BANK_SWITCH && do_write && a == `ADDR_BANK_SEL)
    begin
      bank_ff <= wdat_ff;
    end
  end

  // Storage array carries no reset, it models retained contents
  always_ff @(posedge clk_i)
  begin
    if (do_write && in_window && bank_ok)
    begin
      mem[mem_idx] <= wdat_ff;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fault_ff <= 8'h00;
      warn_ff  <= 8'h00;
    end
    else
    begin
      fault_ff <= nxt_fault;
      warn_ff  <= nxt_warn;
    end
  end

  // Pulses last one cycle, so one write never acts twice
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      clr_st_ff <= 1'b0;
      clr_mt_ff <= 1'b0;
    end
    else
    begin
      clr_st_ff <= wr_clear && wdat_ff[`CLR_ST_BIT];
      clr_mt_ff <= wr_clear && wdat_ff[`CLR_MT_BIT];
    end
  end

  // Levels follow the next flag value, one cycle after the event
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      err_low_ff <= 1'b1;
      war_low_ff <= 1'b1;
    end
    else
    begin
      err_low_ff <= ~|(nxt_fault & `FAULT_MASK);
      war_low_ff <= ~|(nxt_warn & `WARN_MASK);
    end
  end

  assign clear_single_turn_o = clr_st_ff;
  assign clear_revolutions_o = clr_mt_ff;
  assign frame_error_low_o   = err_low_ff;
  assign frame_warning_low_o = war_low_ff;

endmodule : encoder_serial_register_map

// ---- tb/enc_regs_properties.sv ----
`timescale 1ns/10ps
module enc_regs_properties (
  input wire logic       clk_i,                 // Core clock
  input wire logic       arst_n_i,              // Reset
  input wire logic       master_serial_clock_i, // Link clock
  input wire logic [4:0] fault_event_i,         // Fault pulses
  input wire logic [1:0] warn_event_i,          // Warning pulses
  input wire logic       clear_single_turn_o,   // Clear pulse
  input wire logic       clear_revolutions_o,   // Clear pulse
  input wire logic       frame_error_low_o,     // Error level
  input wire logic       frame_warning_low_o    // Warning level
);
  logic [3:0] quiet_ff;

  // Link clock rests low between frames, so this counts idle time
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      quiet_ff <= 4'hf;
    else if (master_serial_clock_i)
      quiet_ff <= 4'h0;
    else if (quiet_ff != 4'hf)
      quiet_ff <= quiet_ff + 4'h1;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  chk_fault_sets_err: assert property (|fault_event_i |=> !frame_error_low_o)
    else $error("error level missed a fault");
  chk_warn_sets_low: assert property (|warn_event_i |=> !frame_warning_low_o)
    else $error("warning level missed a warning");
  chk_err_cause: assert property
    ($rose(frame_error_low_o) |-> $past(fault_event_i) == 5'h00)
    else $error("error level rose on a fault");
  chk_warn_cause: assert property
    ($rose(frame_warning_low_o) |-> $past(warn_event_i) == 2'h0)
    else $error("warning level rose on a warning");
  chk_err_held: assert property
    (quiet_ff == 4'hf && !frame_error_low_o |=> !frame_error_low_o)
    else $error("faults dropped with link idle");
  chk_warn_held: assert property
    (quiet_ff == 4'hf && !frame_warning_low_o |=> !frame_warning_low_o)
    else $error("warnings dropped with link idle");
  chk_st_once: assert property
    (clear_single_turn_o |-> quiet_ff < 4'hc ##1 !clear_single_turn_o [*8])
    else $error("single turn clear not a lone pulse");
  chk_mt_once: assert property
    (clear_revolutions_o |-> quiet_ff < 4'hc ##1 !clear_revolutions_o [*8])
    else $error("revolution clear not a lone pulse");
endmodule : enc_regs_properties

bind encoder_serial_register_map enc_regs_properties u_props (
  .clk_i                 (clk_i),
  .arst_n_i              (arst_n_i),
  .master_serial_clock_i (master_serial_clock_i),
  .fault_event_i         (fault_event_i),
  .warn_event_i          (warn_event_i),
  .clear_single_turn_o   (clear_single_turn_o),
  .clear_revolutions_o   (clear_revolutions_o),
  .frame_error_low_o     (frame_error_low_o),
  .frame_warning_low_o   (frame_warning_low_o)
);

// ---- tb/link_master_model.sv ----
`timescale 1ns/10ps
module link_master_model (
  input  wire logic sout_i, // Read data from device
  output logic      mclk_o, // Link clock, low between frames
  output logic      cmd_o   // Command bit
);
  logic s;

  initial {mclk_o, cmd_o} = 2'b00;

  // Sample the answer just ahead of the rise that shifts the next bit
  task automatic beat(input logic b);
    cmd_o  = b;
    #15;
    s      = sout_i;
    mclk_o = 1'b1;
    #15;
    mclk_o = 1'b0;
  endtask : beat

  task automatic idle(input int n);
    repeat (n) beat(1'b0);
  endtask : idle

  // One byte per frame, one action per write
  task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
    logic [8:0] h;
    h = {1'b1, a, w};
    for (int i = 8; i >= 0; i--)
      beat(h[i]);
    if (!w)
      repeat (4) beat(1'b1);
    for (int i = 7; i >= 0; i--)
    begin
      beat(w ? d[i] : 1'b0);
      q[i] = s;
    end
  endtask : xfer
endmodule : link_master_model

// ---- tb/tb.sv ----
`timescale 1ns/10ps
module tb;
  localparam logic [15:0] PROF = 16'h3c1a;                // Arbitrary value
  localparam logic [31:0] SERN = 32'h9e37_0b42;           // Arbitrary value
  localparam logic [63:0] HIGH = 64'h51c4_77a0_e2d9_06b3; // Arbitrary values

  logic        clk_i = 1'b0;
  logic        arst_n_i, master_serial_clock_i, master_cmd_i, slave_serial_out_o;
  logic        clear_single_turn_o, clear_revolutions_o, frame_error_low_o, frame_warning_low_o;
  logic [4:0]  fault_event_i, fm;
  logic [1:0]  warn_event_i, wm;
  logic [7:0]  rd, mem [10];
  logic [5:0]  off [10];
  logic [31:0] seed = 32'h0001_27ee;
  logic [31:0] v;
  int          err_total, cmp_count, st_cnt, mt_cnt, s0, m0;
  wire logic [1:0] lv = {frame_error_low_o, frame_warning_low_o};

  always #2.5 clk_i = ~clk_i;

  always @(posedge clk_i)
  begin
    st_cnt += int'(clear_single_turn_o === 1'b1);
    mt_cnt += int'(clear_revolutions_o === 1'b1);
  end

  encoder_serial_register_map #(
    .PROFILE_IDENTIFIER (PROF),
    .SERIAL_NUM (SERN),
    .PART_ID    (HIGH[63:16]),
    .MAKER_ID   (HIGH[15:0])
  ) DUT (
    .clk_i                 (clk_i),
    .arst_n_i              (arst_n_i),
    .master_serial_clock_i (master_serial_clock_i),
    .master_cmd_i          (master_cmd_i),
    .slave_serial_out_o    (slave_serial_out_o),
    .fault_event_i         (fault_event_i),
    .warn_event_i          (warn_event_i),
    .clear_single_turn_o   (clear_single_turn_o),
    .clear_revolutions_o   (clear_revolutions_o),
    .frame_error_low_o     (frame_error_low_o),
    .frame_warning_low_o   (frame_warning_low_o)
  );

  link_master_model master (
    .sout_i (slave_serial_out_o),
    .mclk_o (master_serial_clock_i),
    .cmd_o  (master_cmd_i)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Identity bytes big-endian; every other fixed byte reads zero
  function automatic logic [7:0] id_byte(input int a);
    logic [47:0] lo;
    lo = {PROF, SERN};
    if (a >= 8'h42 && a <= 8'h47)
      return lo[8 * (8'h47 - a) +: 8];
    if (a >= 8'h78)
      return HIGH[8 * (8'h7f - a) +: 8];
    return 8'h00;
  endfunction : id_byte

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    master.xfer(a, 1'b1, d, rd);
  endtask : wr

  task automatic rdc(input logic [6:0] a, input logic [7:0] e, input string n);
    master.xfer(a, 1'b0, 8'h00, rd);
    chk(n, e, rd);
  endtask : rdc

  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  initial
  begin
    arst_n_i      = 1'b0;
    fault_event_i = 5'h00;
    warn_event_i  = 2'h0;
    fork
      repeat (4) @(posedge clk_i);
      master.idle(2);
    join
    @(posedge clk_i);
    arst_n_i <= 1'b1;
    master.idle(2);
    chk("idle levels", 8'h07, {5'h00, slave_serial_out_o, lv});
    for (int a = 8'h41; a < 8'h80; a++)
    begin
      v = rnd();
      if (a != 8'h4a)
        wr(7'(a), v[7:0]);
      rdc(7'(a), id_byte(a), "fixed byte");
    end
    for (int b = 0; b < 10; b++)
    begin
      v = rnd();
      off[b] = v[5:0];
      mem[b] = v[15:8];
      wr(7'h40, 8'(b));
      wr(7'(off[b]), mem[b]);
    end
    for (int b = 0; b < 10; b++)
    begin
      wr(7'h40, 8'(b));
      rdc(7'h40, 8'(b), "bank select");
      rdc(7'(off[b]), mem[b], "bank byte");
    end
    wr(7'h40, 8'h0a);
    wr(7'(off[0]), ~mem[0]);
    rdc(7'(off[0]), 8'h00, "hidden window");
    wr(7'h40, 8'h00);
    rdc(7'(off[0]), mem[0], "dropped write");
    for (int i = 0; i < 7; i++)
    begin
      v = rnd();
      fm = (i < 5) ? 5'(1 << i) : v[4:0] | 5'h01;
      wm = (i < 2) ? 2'(1 << i) : v[9:8] | 2'h1;
      @(posedge clk_i);
      fault_event_i <= fm;
      warn_event_i  <= wm;
      @(posedge clk_i);
      fault_event_i <= 5'h00;
      warn_event_i  <= 2'h0;
      @(posedge clk_i);
      #1;
      chk("frame levels", 8'h00, {6'h00, lv});
      rdc(7'h48, {3'h0, fm}, "fault flags");
      rdc(7'h49, {6'h00, wm}, "warning flags");
      wr(7'h4a, 8'h04);
      rdc(7'h48, 8'h00, "faults cleared");
      rdc(7'h49, {6'h00, wm}, "warnings kept");
      chk("levels after clear", 8'h02, {6'h00, lv});
      wr(7'h4a, 8'h08);
      rdc(7'h49, 8'h00, "warnings cleared");
    end
    chk("levels restored", 8'h03, {6'h00, lv});
    for (int k = 0; k < 2; k++)
    begin
      s0 = st_cnt;
      m0 = mt_cnt;
      wr(7'h4a, 8'h02 >> k);
      repeat (20) @(posedge clk_i);
      chk("single turn clears", 8'(1 - k), 8'(st_cnt - s0));
      chk("revolution clears", 8'(k), 8'(mt_cnt - m0));
    end
    rdc(7'h4a, 8'h00, "clear readback");
    wrap_up();
  end
endmodule : tb
